// ==== logic/adc_start_trig_regs.vh ====
// register map, field positions and reset values of the converter start/trigger block
`ifndef ADC_START_TRIG_REGS_VH
`define ADC_START_TRIG_REGS_VH

`define CONV_CONTROL_ADDR      12'h000
`define CONV_TRIG_SELECT_ADDR  12'h004
`define CONV_MODE_STATUS_ADDR  12'h008

`define CONV_GO_BIT            13
`define MOD1_GROUP1_TRIG_MSB   15
`define MOD1_GROUP1_TRIG_LSB   12
`define MOD0_GROUP1_TRIG_MSB   11
`define MOD0_GROUP1_TRIG_LSB   8
`define MOD1_TRIG_MSB          7
`define MOD1_TRIG_LSB          4
`define MOD0_TRIG_MSB          3
`define MOD0_TRIG_LSB          0

`define CONV_DONE_FLAG_BIT     15
`define HW_TRIGGER_GATE_BIT    11
`define CONV_MODE_MSB          5
`define CONV_MODE_LSB          4

`define MODE_SINGLE            2'h0
`define MODE_SCAN4             2'h1
`define MODE_SCAN2             2'h2

`define TRIG_SELECT_RESET      16'h0000
`define CONV_MODE_RESET        2'h0
`endif

// ==== logic/adc_start_trigger_control.v ====
// converter start, stop and trigger-source selection with an apb register port
`timescale 1ns/10ps
`include "adc_start_trig_regs.vh"
// Behaviour
// - go bit low halts converter, idle
// - writing go bit starts conversion
// - single mode clears go at end
// - bits 15:12 pick module 1 group-1 trigger
// - bits 11:8 pick module 0 group-1 trigger
// - bits 7:4 pick module 1 trigger
// - bits 3:0 pick module 0 trigger
// - trigger select resets to zero
// - done flag set at scan end, read-then-clear
// - trigger gate bit high blocks triggers
// - two-bit mode field selects conversion mode
//
// notes for integration
// - register map: control word, trigger select word, mode and status word
// - the control word stores only the go bit; every other bit reads zero
// - software keeps reserved control bits at zero; hardware ignores them
// - the go bit is the converter's run level: high converts, low idles
// - clearing go halts the core at once; no conversion is finished first
// - in single mode the core's end pulse drops go by itself
// - in the scan modes go stays high; the end pulse raises the done flag
// - mode code three is taken as a scan mode, so go is kept there too
// - the done flag clears only by writing zero after reading it as one
// - a read that sees the flag set arms the clear; a later write uses it
// - a set from an end pulse wins over a clear written in the same cycle
// - a hardware trigger wins over a software or end-of-single clear
// - the trigger gate bit is active high: one blocks every trigger
// - trigger select codes index the sixteen source pulses directly
// - module 0 start comes from its own field, or from its group-1 field
//   while the mode field says two-channel scan
// - module 1 fields only leave as registered trigger pulses, one cycle
//   after the source pulse; the module 1 core owns its own go bit
// - sources are taken as synchronous pulses, one clock wide
//
// bus timing
// - one wait state on every transfer: pready rises in the second cycle
//   of the access phase and stands for one cycle
// - a write lands at the edge where psel, penable and pready are all high
// - read data is launched with pready and is zero at every other time
// - an unmapped address answers with pslverr and zero data, no write
//
// trade-offs
// - converter outputs are registered copies of the next-state values, so the
//   converter sees go in the same cycle as the internal register
// - a fixed wait state costs one cycle per access but keeps the read
//   mux off the bus output path
module adc_start_trigger_control (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // conversion core
  input  wire        i_conv_end,
  output reg         o_conv_go,
  output reg  [1:0]  o_conv_mode,
  output reg         o_conv_done_flag,
  // trigger sources and module 1 trigger outputs
  input  wire [15:0] i_trig_src,
  output reg         o_mod1_trig,
  output reg         o_mod1_group1_trig
);

  reg  [15:0] trig_sel_reg;
  reg  [1:0]  mode_reg;
  reg         gate_reg;
  reg         go_reg;
  reg         done_reg;
  reg         done_seen_reg;
  reg  [15:0] trig_sel_next;
  reg  [1:0]  mode_next;
  reg         gate_next;
  reg         go_next;
  reg         done_next;
  reg         done_seen_next;
  reg  [31:0] rdata_next;
  reg         err_next;
  wire        xfer_done;
  wire        wr_en;
  wire        rd_en;
  wire        answer_now;
  wire        trig_ok;
  wire        mod0_trig;
  wire        mod0_group1_trig;
  wire        is_scan2;
  wire [3:0]  field_hit;
  genvar      f;

  // one wait state: pready rises one cycle into the access phase
  assign answer_now = i_psel & i_penable & ~o_pready;
  assign xfer_done  = i_psel & i_penable & o_pready;
  assign wr_en      = xfer_done & i_pwrite;
  assign rd_en      = xfer_done & ~i_pwrite;

  // source selection per field; an active-high gate bit disables triggering
  assign trig_ok          = ~gate_reg;
  assign is_scan2         = (mode_reg == `MODE_SCAN2);
  // one selector per field: 0 module 0, 1 module 1, 2 module 0 group 1, 3 module 1 group 1
  generate
    for (f = 0; f < 4; f = f + 1) begin : g_field
      assign field_hit[f] = i_trig_src[trig_sel_reg[4*f+3:4*f]];
    end
  endgenerate
  assign mod0_trig        = field_hit[0];
  assign mod0_group1_trig = field_hit[2] & is_scan2;

  // register next-state logic
  always @* begin
    trig_sel_next  = trig_sel_reg;
    mode_next      = mode_reg;
    gate_next      = gate_reg;
    go_next        = go_reg;
    done_next      = done_reg;
    done_seen_next = done_seen_reg;
    if (wr_en) begin
      if (i_paddr == `CONV_CONTROL_ADDR) begin
        // only the go bit is stored; other bits are reserved and kept at zero by software
        go_next = i_pwdata[`CONV_GO_BIT];
      end else if (i_paddr == `CONV_TRIG_SELECT_ADDR) begin
        trig_sel_next = i_pwdata[15:0];
      end else if (i_paddr == `CONV_MODE_STATUS_ADDR) begin
        mode_next = i_pwdata[`CONV_MODE_MSB:`CONV_MODE_LSB];
        gate_next = i_pwdata[`HW_TRIGGER_GATE_BIT];
        // the flag only clears if software saw it set first
        if (!i_pwdata[`CONV_DONE_FLAG_BIT] && done_seen_reg) begin
          done_next      = 1'b0;
          done_seen_next = 1'b0;
        end
      end
    end
    if (rd_en && (i_paddr == `CONV_MODE_STATUS_ADDR) && done_reg) begin
      done_seen_next = 1'b1;
    end
    // end of conversion: single mode drops go, scan modes raise the flag
    if (i_conv_end && go_reg) begin
      if (mode_reg == `MODE_SINGLE) begin
        go_next = 1'b0;
      end else begin
        done_next = 1'b1;
      end
    end
    // a hardware trigger wins over a same-cycle clear
    if (trig_ok && (mod0_trig || mod0_group1_trig)) begin
      go_next = 1'b1;
    end
  end

  // read mux and unmapped-address answer
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    if (i_paddr == `CONV_CONTROL_ADDR) begin
      rdata_next[`CONV_GO_BIT] = go_reg;
    end else if (i_paddr == `CONV_TRIG_SELECT_ADDR) begin
      rdata_next[15:0] = trig_sel_reg;
    end else if (i_paddr == `CONV_MODE_STATUS_ADDR) begin
      rdata_next[`CONV_DONE_FLAG_BIT]              = done_reg;
      rdata_next[`HW_TRIGGER_GATE_BIT]             = gate_reg;
      rdata_next[`CONV_MODE_MSB:`CONV_MODE_LSB]    = mode_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // state registers
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      trig_sel_reg  <= `TRIG_SELECT_RESET;
      mode_reg      <= `CONV_MODE_RESET;
      gate_reg      <= 1'b0;
      go_reg        <= 1'b0;
      done_reg      <= 1'b0;
      done_seen_reg <= 1'b0;
    end else begin
      trig_sel_reg  <= trig_sel_next;
      mode_reg      <= mode_next;
      gate_reg      <= gate_next;
      go_reg        <= go_next;
      done_reg      <= done_next;
      done_seen_reg <= done_seen_next;
    end
  end

  // registered outputs; module 1 triggers leave one cycle after the source pulse
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_prdata           <= 32'h0000_0000;
      o_pready           <= 1'b0;
      o_pslverr          <= 1'b0;
      o_conv_go          <= 1'b0;
      o_conv_mode        <= `CONV_MODE_RESET;
      o_conv_done_flag   <= 1'b0;
      o_mod1_trig        <= 1'b0;
      o_mod1_group1_trig <= 1'b0;
    end else begin
      o_pready           <= answer_now;
      o_pslverr          <= answer_now & err_next;
      o_prdata           <= answer_now ? rdata_next : 32'h0000_0000;
      o_conv_go          <= go_next;
      o_conv_mode        <= mode_next;
      o_conv_done_flag   <= done_next;
      o_mod1_trig        <= trig_ok & field_hit[1];
      o_mod1_group1_trig <= trig_ok & is_scan2 & field_hit[3];
    end
  end

endmodule // adc_start_trigger_control

// ==== verif/adc_start_trigger_control_chk.sv ====
// assertions on the apb answer and go-bit behaviour of the start/trigger block
`timescale 1ns/10ps
module adc_start_trigger_control_chk (
  // clock and reset
  input wire        i_ref_clk,
  input wire        i_rst,
  // watched design ports
  input wire        i_psel,
  input wire        i_conv_end,
  input wire [15:0] i_trig_src,
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire        o_conv_go,
  input wire        o_conv_done_flag,
  input wire [1:0]  o_conv_mode
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_rd0; !o_pready |-> o_prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("stale read data");
  // no write and no trigger: an idle converter stays idle
  property p_idle; !i_psel && !o_conv_go && i_trig_src == 16'h0 |=> !o_conv_go; endproperty
  a_idle: assert property (p_idle) else $error("go rose unasked");
  property p_auto; !i_psel && o_conv_go && i_conv_end && o_conv_mode == 2'h0 &&
    i_trig_src == 16'h0 |=> !o_conv_go; endproperty
  a_auto: assert property (p_auto) else $error("single go kept");
  property p_keep; !i_psel && o_conv_go && o_conv_mode != 2'h0 |=> o_conv_go; endproperty
  a_keep: assert property (p_keep) else $error("scan go dropped");
  property p_mode; !i_psel |=> $stable(o_conv_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_flag; $rose(o_conv_done_flag) |-> $past(i_conv_end); endproperty
  a_flag: assert property (p_flag) else $error("flag without end");
endmodule // adc_start_trigger_control_chk

// ==== verif/conv_core_model.sv ====
// behavioural converter core answering the go bit with end pulses
`timescale 1ns/10ps
module conv_core_model (
  input  wire       i_ref_clk,
  input  wire       i_go,
  input  wire [3:0] i_lat,
  output reg        o_end = 1'h0
);
  reg [3:0] cnt_reg = 4'h0;
  // count wraps, so a scan keeps ending every sixteen cycles
  always @(posedge i_ref_clk) begin
    cnt_reg <= i_go ? cnt_reg + 4'h1 : 4'h0;
    o_end   <= i_go && cnt_reg == i_lat;
  end
endmodule // conv_core_model

// ==== verif/adc_start_trigger_control_test.sv ====
// self-checking bench for the converter start and trigger block
`timescale 1ns/10ps
`include "adc_start_trig_regs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t %h %h", $time, a, b); end end
module adc_start_trigger_control_test;
  reg         i_ref_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, e, g, m, mg;
  reg  [11:0] i_paddr = 12'h0;
  reg  [31:0] i_pwdata = 32'h0, q;
  reg  [15:0] i_trig_src = 16'h0;
  reg  [3:0]  lat = 4'h3, k;
  reg  [15:0] r;
  wire [31:0] o_prdata;
  wire [1:0]  o_conv_mode;
  wire        o_pready, o_pslverr, i_conv_end, o_conv_go, o_conv_done_flag;
  wire        o_mod1_trig, o_mod1_group1_trig;
  integer     fail_count = 0, cmp_count = 0, i, n;
  always #10 i_ref_clk = ~i_ref_clk;
  adc_start_trigger_control dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_conv_end(i_conv_end),
    .o_conv_go(o_conv_go), .o_conv_mode(o_conv_mode), .o_conv_done_flag(o_conv_done_flag),
    .i_trig_src(i_trig_src), .o_mod1_trig(o_mod1_trig),
    .o_mod1_group1_trig(o_mod1_group1_trig));
  conv_core_model core (.i_ref_clk(i_ref_clk), .i_go(o_conv_go), .i_lat(lat), .o_end(i_conv_end));
  // request held until pready is seen high at a rising edge
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_ref_clk) i_penable <= 1;
      n = 0;
      do begin @(posedge i_ref_clk); n++; end while (o_pready !== 1 && n < 20);
      q = o_prdata; e = o_pslverr; i_psel <= 0; i_penable <= 0;
      @(posedge i_ref_clk);
    end
  endtask
  // one-cycle pulse on a trigger source, then note what answered
  task fire(input [3:0] s);
    begin
      i_trig_src <= 16'h1 << s;
      @(posedge i_ref_clk) i_trig_src <= 16'h0;
      g = 0; m = 0; mg = 0;
      repeat (3) begin @(posedge i_ref_clk); g |= o_conv_go; m |= o_mod1_trig;
        mg |= o_mod1_group1_trig; end
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #400000 fail_count++;
    test_done;
  end
  initial begin
    void'($urandom(32'he143));
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 0;
    @(posedge i_ref_clk);
    apb(0, `CONV_TRIG_SELECT_ADDR, 0); `CHK(q, 32'h0)
    apb(0, 12'hffc, 0); `CHK({e, q}, 33'h100000000)
    // every select code; module 0 field differs so selection is visible
    for (i = 0; i < 16; i++) begin
      k = i; lat = $urandom;
      apb(1, `CONV_MODE_STATUS_ADDR, 0);
      r = $urandom;
      apb(1, `CONV_TRIG_SELECT_ADDR, {16'h0, r});
      apb(0, `CONV_TRIG_SELECT_ADDR, 0); `CHK(q, {16'h0, r})
      apb(1, `CONV_TRIG_SELECT_ADDR, {k, k, k, ~k});
      fire(k); `CHK({g, m, mg}, 3'h2)
      fire(~k); `CHK(g, 1'h1)
      for (n = 0; o_conv_go && n < 40; n++) @(posedge i_ref_clk);
      `CHK(o_conv_go, 1'h0)
      apb(1, `CONV_CONTROL_ADDR, 32'h2000); `CHK(o_conv_go, 1'h1)
      apb(1, `CONV_MODE_STATUS_ADDR, 32'h20);
      apb(1, `CONV_CONTROL_ADDR, 0); `CHK(o_conv_go, 1'h0)
      fire(k); `CHK({g, mg}, 2'h3)
      apb(1, `CONV_CONTROL_ADDR, 0);
      apb(1, `CONV_MODE_STATUS_ADDR, 32'h820);
      fire(k); `CHK({g, mg}, 2'h0)
    end
    apb(1, `CONV_MODE_STATUS_ADDR, 32'h10); `CHK(o_conv_mode, 2'h1)
    apb(1, `CONV_CONTROL_ADDR, 32'h2000);
    repeat (40) @(posedge i_ref_clk);
    `CHK({o_conv_go, o_conv_done_flag}, 2'h3)
    apb(1, `CONV_CONTROL_ADDR, 0); `CHK(o_conv_go, 1'h0)
    apb(0, `CONV_MODE_STATUS_ADDR, 0); `CHK(q[15], 1'h1)
    apb(1, `CONV_MODE_STATUS_ADDR, 32'h10); `CHK(o_conv_done_flag, 1'h0)
    test_done;
  end
endmodule // adc_start_trigger_control_test
bind adc_start_trigger_control adc_start_trigger_control_chk chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel), .i_conv_end(i_conv_end),
  .i_trig_src(i_trig_src), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_conv_go(o_conv_go), .o_conv_done_flag(o_conv_done_flag),
  .o_conv_mode(o_conv_mode));
